// ==== common/fault_dispatch_consts.svh ====
// Constants for the fault dispatch unit.
// What this block does
// [RL1] Record fault type and subtype, then choose the handler by type alone.
// [RL2] Fault word at record offset 40: type in bits 23:16, subtype in 7:0.
// [RL3] Trace faults are type 1, subtype bits 1 through 7 per trace kind.
// [RL4] Operation faults are type 2: subtype 1 bad opcode, 4 bad operand.
// [RL5] Arithmetic faults are type 3: subtype 1 overflow, 2 zero-divide.
// [RL6] Floating faults are type 4, subtype bits 0 through 5 per condition.
// [RL7] Constraint faults are type 5: subtype 1 range, 2 bad selector.
// [RL8] Virtual-memory faults are type 6: subtypes 1, 2, 3 for table entries.
// [RL9] Protection faults are type 7: subtype 1 segment length, 2 page rights.
// [RL10] Machine bad access is type 8/1; structural is type 9 subtypes 1-3.
// [RL11] Type fault 0xA/1-2, time slice 0xC/1, descriptor 0xD/1, event 0xE/1.
// [RL12] Bit-coded types report all simultaneous subtype bits in one record.
// [RL13] A fault while running indexes the fault table and calls the handler.
// [RL14] Handler call is local, procedure-table, supervisor or trace-table call.
// [RL15] Save state, push fault record, maybe resumption record, then start handler.
// [RL16] Faults inside interrupt or fault handlers use the same call path.
// [RL17] Faults are detected while running, in handlers, and while idle.
// [RL18] Fault during record storing is an override: store both, call override handler.
// [RL19] On override handler return, re-raise the primary fault normally.
// [RL20] Fault while storing override records escalates to system-error interrupt.
// [RL21] System error saves all three faults in control block, vector 248, no return.
// [RL22] Fault during system-error generation halts after capturing the last fault.
// [RL23] Entry word bits 1:0: 00 local call, 10 procedure-table call via word two.
// [RL24] Nesting level none/override/system-error, set at storing, cleared at handler start.
`ifndef FAULT_DISPATCH_CONSTS_SVH
`define FAULT_DISPATCH_CONSTS_SVH
`define FT_TRACE 8'h01
`define FT_OPER 8'h02
`define FT_ARITH 8'h03
`define FT_FLOAT 8'h04
`define FT_CONSTR 8'h05
`define FT_VMEM 8'h06
`define FT_PROT 8'h07
`define FT_MACH 8'h08
`define FT_STRUCT 8'h09
`define FT_TYPE 8'h0A
`define FT_PROC 8'h0C
`define FT_DESC 8'h0D
`define FT_EVENT 8'h0E
`define FT_OVERRIDE 8'h00
`define REC_WORD_OFS 8'h28
`define REC_TYPE_LSB 16
`define REC_SUB_LSB 0
`define SYSERR_VECTOR 8'hF8
`define ENTRY_LOCAL 2'h0
`define ENTRY_PROC 2'h2
`define ENTRY_WORD_BYTES 32'h00000008
`define STORE_WORDS 4'h4
`endif

// ==== common/fault_dispatch_pkg.sv ====
// Types shared by the fault dispatch unit.
package fault_dispatch_pkg;
  typedef enum logic [1:0] {NEST_NONE, NEST_OVERRIDE, NEST_SYSERR} nest_e;
  typedef enum logic [1:0] {CALL_LOCAL, CALL_PROC_LOCAL, CALL_SUPER, CALL_TRACE} call_e;
  // Raw fault conditions from the datapath, one bit per subtype.
  typedef struct packed {
    logic [6:0] trace;     // Instruction .. breakpoint.
    logic [1:0] oper;      // Opcode, operand.
    logic [1:0] arith;     // Overflow, zero-divide.
    logic [5:0] fpu;       // Overflow .. reserved encoding.
    logic [1:0] constr;    // Range, selector.
    logic [2:0] vmem;      // Segment, page dir, page table entry.
    logic [1:0] prot;      // Segment length, page rights.
    logic mach;
    logic [2:0] structural; // Control, dispatch, message.
    logic [1:0] typ;       // Mismatch, contents.
    logic time_slice;
    logic desc;
    logic event_notice;
  } fault_cond_s;
  typedef struct packed {
    logic [7:0] ftype;
    logic [7:0] subtype;
  } fault_code_s;
  // Fault-table entry as fetched from memory.
  typedef struct packed {
    logic [31:0] word0;
    logic [31:0] word1;
  } table_entry_s;
endpackage

// ==== rtl/fault_classify.sv ====
// Priority classifier that turns raw fault conditions into a type and subtype.
`timescale 1ns/1ns
`default_nettype none
`include "fault_dispatch_consts.svh"
module fault_classify
  import fault_dispatch_pkg::*;
(
  input wire fault_cond_s cond,
  output logic any,
  output fault_code_s code
);
  // One fault is reported; bit-coded types carry every simultaneous bit.
  always_comb begin
    any = 1'b1;
    code = '0;
    // [RL3] Trace bit coding.
    if (|cond.trace) begin
      code = '{`FT_TRACE, {cond.trace, 1'b0}};
    // [RL4] Operation codes.
    end else if (|cond.oper) begin
      code = '{`FT_OPER, cond.oper[0] ? 8'h01 : 8'h04};
    // [RL5] Arithmetic codes.
    end else if (|cond.arith) begin
      code = '{`FT_ARITH, cond.arith[0] ? 8'h01 : 8'h02};
    // [RL6] Floating bit coding.
    end else if (|cond.fpu) begin
      code = '{`FT_FLOAT, {2'h0, cond.fpu}};
    // [RL7] Constraint codes.
    end else if (|cond.constr) begin
      code = '{`FT_CONSTR, cond.constr[0] ? 8'h01 : 8'h02};
    // [RL8] Virtual memory codes.
    end else if (|cond.vmem) begin
      code = '{`FT_VMEM, cond.vmem[0] ? 8'h01 : (cond.vmem[1] ? 8'h02 : 8'h03)};
    // [RL9] Protection with both bits, [RL12] group reporting.
    end else if (|cond.prot) begin
      code = '{`FT_PROT, {6'h00, cond.prot}};
    // [RL10] Machine and structural codes.
    end else if (cond.mach) begin
      code = '{`FT_MACH, 8'h01};
    end else if (|cond.structural) begin
      code = '{`FT_STRUCT, cond.structural[0] ? 8'h01 :
               (cond.structural[1] ? 8'h02 : 8'h03)};
    // [RL11] Type, process, descriptor, event codes.
    end else if (|cond.typ) begin
      code = '{`FT_TYPE, cond.typ[0] ? 8'h01 : 8'h02};
    end else if (cond.time_slice) begin
      code = '{`FT_PROC, 8'h01};
    end else if (cond.desc) begin
      code = '{`FT_DESC, 8'h01};
    end else if (cond.event_notice) begin
      code = '{`FT_EVENT, 8'h01};
    end else begin
      any = 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/fault_dispatch_unit.sv ====
// Fault dispatch: classify, store records, call handlers, escalate nested faults.
`timescale 1ns/1ns
`default_nettype none
`include "fault_dispatch_consts.svh"
module fault_dispatch_unit
  import fault_dispatch_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire fault_cond_s cond,          // From datapath, same clock.
  input wire logic partial_instr,        // Faulting instruction is half done.
  input wire logic idle,                 // Core is between processes.
  input wire logic [ADDR_W-1:0] table_base,
  output logic tbl_req,                  // Fetch fault-table entry.
  output logic [ADDR_W-1:0] tbl_addr,
  input wire logic tbl_ack,
  input wire table_entry_s tbl_entry,
  output logic store_req,                // Push one record word.
  output logic [7:0] store_ofs,
  output logic [31:0] store_data,
  output logic store_to_ctl_block,       // Target is the processor_control_block.
  input wire logic store_ack,
  output logic call_valid,               // Start handler.
  output call_e call_kind,
  output logic [31:0] call_target,
  output logic [31:0] call_selector,
  input wire logic handler_started,      // First handler instruction issued.
  input wire logic override_return,      // Override handler returned.
  output logic syserr_valid,
  output logic [7:0] syserr_vector,
  output logic stopped,
  output nest_e nest
);
  typedef enum logic [2:0] {S_IDLE, S_STORE, S_FETCH, S_CALL, S_WAIT, S_SYSERR, S_HALT} st_e;
  st_e st;
  logic any;
  fault_code_s code;
  fault_code_s primary;
  fault_code_s secondary;
  fault_code_s third;
  logic resume;
  logic [3:0] word_cnt;
  logic [31:0] fault_word;

  fault_classify fault_classify_i (
    .cond(cond),
    .any(any),
    .code(code)
  );

  // [RL2] Record word layout.
  assign fault_word = {8'h00, code.ftype, 8'h00, code.subtype};

  // Records go to the handler's stack, or to the control block on system error.
  always_comb begin
    store_ofs = `REC_WORD_OFS;
    store_data = {8'h00, primary.ftype, 8'h00, primary.subtype};
    if (word_cnt == 4'h1) begin
      store_data = {8'h00, secondary.ftype, 8'h00, secondary.subtype};
    end else if (word_cnt == 4'h2) begin
      store_data = {8'h00, third.ftype, 8'h00, third.subtype};
    end else if (word_cnt == 4'h3) begin
      store_data = {31'h0, resume};
    end
  end
  assign store_req = (st == S_STORE);
  assign store_to_ctl_block = (nest == NEST_SYSERR);
  assign tbl_req = (st == S_FETCH);
  assign syserr_vector = `SYSERR_VECTOR;

  // [RL13] Table index by type; override uses entry zero.
  always_comb begin
    tbl_addr = table_base + ADDR_W'(primary.ftype) * ADDR_W'(`ENTRY_WORD_BYTES);
    if (nest == NEST_OVERRIDE) begin
      tbl_addr = table_base;
    end
  end

  // Main sequencer.
  // [RL17] Idle or busy, detection is on in every state but S_HALT; idle escalates.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st <= S_IDLE;
      nest <= NEST_NONE;
      primary <= '0;
      secondary <= '0;
      third <= '0;
      resume <= 1'b0;
      word_cnt <= '0;
      call_valid <= 1'b0;
      call_kind <= CALL_LOCAL;
      call_target <= '0;
      call_selector <= '0;
      syserr_valid <= 1'b0;
      stopped <= 1'b0;
    end else begin
      call_valid <= 1'b0;
      syserr_valid <= 1'b0;
      case (st)
        S_IDLE: begin
          if (any) begin
            // [RL1] Capture the code first.
            primary <= code;
            resume <= partial_instr;
            word_cnt <= '0;
            // [RL24] Nesting set on storing.
            nest <= idle ? NEST_SYSERR : NEST_NONE;
            st <= S_STORE;
          end else if (override_return) begin
            // [RL19] Refault on primary.
            nest <= NEST_NONE;
            word_cnt <= '0;
            st <= S_STORE;
          end
        end
        S_STORE, S_FETCH, S_CALL, S_WAIT: begin
          if (any && nest == NEST_NONE) begin
            // [RL18] Override entry.
            secondary <= code;
            nest <= NEST_OVERRIDE;
            word_cnt <= '0;
            st <= S_STORE;
          end else if (any && nest == NEST_OVERRIDE) begin
            // [RL20] Second override escalates.
            third <= code;
            nest <= NEST_SYSERR;
            word_cnt <= '0;
            st <= S_STORE;
          end else if (any && nest == NEST_SYSERR) begin
            // [RL22] Halt, keep the last fault.
            third <= code;
            stopped <= 1'b1;
            st <= S_HALT;
          end else begin
            case (st)
              S_STORE: begin
                // [RL15] Push record words, resumption last.
                if (store_ack) begin
                  word_cnt <= word_cnt + 4'h1;
                  if (word_cnt == `STORE_WORDS - 4'h1) begin
                    st <= (nest == NEST_SYSERR) ? S_SYSERR : S_FETCH;
                  end
                end
              end
              S_FETCH: begin
                if (tbl_ack) begin
                  // [RL23] Entry type decode; [RL14] four call forms.
                  call_target <= {tbl_entry.word0[31:2], 2'b00};
                  call_selector <= tbl_entry.word1;
                  if (tbl_entry.word0[1:0] == `ENTRY_LOCAL) begin
                    call_kind <= CALL_LOCAL;
                  end else if (primary.ftype == `FT_TRACE) begin
                    call_kind <= CALL_TRACE;
                  end else if (tbl_entry.word0[31:2] == 30'h0) begin
                    call_kind <= CALL_SUPER;
                  end else begin
                    call_kind <= CALL_PROC_LOCAL;
                  end
                  st <= S_CALL;
                end
              end
              S_CALL: begin
                // [RL16] Same call regardless of context.
                call_valid <= 1'b1;
                st <= S_WAIT;
              end
              default: begin
                // [RL24] Cleared when handler starts.
                // The level drops here so that nest reads none while S_IDLE waits for the next fault.
                if (handler_started) begin
                  nest <= NEST_NONE;
                  st <= S_IDLE;
                end
              end
            endcase
          end
        end
        S_SYSERR: begin
          // [RL21] Dispatch vector, no return path.
          if (any) begin
            third <= code;
            stopped <= 1'b1;
            st <= S_HALT;
          end else begin
            syserr_valid <= 1'b1;
            st <= S_HALT;
          end
        end
        S_HALT: begin
          stopped <= stopped;
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

  // Assertions.
  AST_CALL_AFTER_STORE: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL15]
    call_valid |-> $past(st) == S_CALL) else $error("call without fetch");
  AST_WORD_LAYOUT: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL2]
    fault_word[23:16] == code.ftype && fault_word[7:0] == code.subtype)
    else $error("fault word layout wrong");
  AST_OVERRIDE: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL18]
    (st == S_STORE && any && nest == NEST_NONE) |=> nest == NEST_OVERRIDE)
    else $error("override not entered");
  AST_ESCALATE: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL20]
    (st == S_STORE && any && nest == NEST_OVERRIDE) |=> nest == NEST_SYSERR)
    else $error("no escalation");
  AST_SYSERR_VEC: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL21]
    syserr_valid |-> syserr_vector == `SYSERR_VECTOR && $past(st) == S_SYSERR)
    else $error("bad vector");
  AST_HALT: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL22]
    (st == S_STORE && any && nest == NEST_SYSERR) |=> stopped ##1 stopped)
    else $error("no halt");
  AST_TABLE_INDEX: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL13]
    (tbl_req && nest == NEST_NONE) |-> tbl_addr == table_base +
      ADDR_W'(primary.ftype) * ADDR_W'(`ENTRY_WORD_BYTES)) else $error("bad table index");
  // The nesting level is back to none once the chosen handler has started.
  AST_NEST_CLEAR: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL24]
    (st == S_WAIT && handler_started && !any) |=> nest == NEST_NONE && st == S_IDLE)
    else $error("nesting level not cleared");
  AST_LOCAL_CALL: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL23]
    (tbl_req && tbl_ack && tbl_entry.word0[1:0] == 2'b00) |=> call_kind == CALL_LOCAL
    ##1 call_valid) else $error("local entry misdecoded");
  AST_CLASSIFY_FP: assert property (@(posedge ref_clk) disable iff (!resetn) // [RL6]
    (any && code.ftype == 8'h04) |-> code.subtype[5:0] == cond.fpu)
    else $error("floating subtype bits lost");
endmodule
`default_nettype wire

// ==== verification/fault_dispatch_partner.sv ====
// Far-side model: fault table memory, record stack and handler start.
`timescale 1ns/1ns
`default_nettype none
module fault_dispatch_partner
  import fault_dispatch_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic [31:0] table_base,
  input wire logic tbl_req,
  input wire logic [31:0] tbl_addr,
  output logic tbl_ack,
  output table_entry_s tbl_entry,
  input wire logic store_req,
  output logic store_ack,
  input wire logic call_valid,
  output logic handler_started
);
  logic [3:0] wait_cnt;
  logic [2:0] start_pipe;
  logic [7:0] idx;
  table_entry_s entry;

  // Entry number from the fetch address, eight bytes per entry.
  assign idx = 8'((tbl_addr - table_base) >> 3);

  // entry kinds
  // Entry 1 is the trace-table entry, 2 a procedure-table entry, 5 the supervisor form.
  always_comb begin
    entry.word1 = 32'h00000A00 + {24'h0, idx};
    if (idx == 8'h01) entry.word0 = 32'h00000402;
    else if (idx == 8'h02) entry.word0 = 32'h00000302;
    else if (idx == 8'h05) entry.word0 = 32'h00000002;
    else entry.word0 = 32'h00010000 + {16'h0, idx, 8'h00};
  end

  // Outside an acknowledge the data lines carry the inverse, so stale data never looks valid.
  assign tbl_entry = tbl_ack ? entry : ~entry;

  // One acknowledge per request after no wait or five cycles of latency.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wait_cnt <= 4'h0;
      tbl_ack <= 1'b0;
      store_ack <= 1'b0;
    end else begin
      tbl_ack <= 1'b0;
      store_ack <= 1'b0;
      if ((tbl_req || store_req) && !tbl_ack && !store_ack) begin
        if (wait_cnt >= (slow ? 4'h5 : 4'h0)) begin
          tbl_ack <= tbl_req;
          store_ack <= store_req && !tbl_req;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end
    end
  end

  // The handler's first instruction issues four cycles after the call.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      start_pipe <= 3'h0;
      handler_started <= 1'b0;
    end else begin
      start_pipe <= {start_pipe[1:0], call_valid};
      handler_started <= start_pipe[2];
    end
  end
endmodule
`default_nettype wire

// ==== verification/fault_dispatch_unit_tb_top.sv ====
// Self-checking bench for the fault dispatch unit.
`timescale 1ns/1ns
`default_nettype none
`include "fault_dispatch_consts.svh"
module fault_dispatch_unit_tb_top;
  import fault_dispatch_pkg::*;
  // Condition bit, type and subtype of 24 single faults; trace and floating only at their end bits.
  localparam logic [23:0] CODES [24] = '{24'h1A0102, 24'h200180, 24'h180201, 24'h190204,
    24'h160301, 24'h170302, 24'h100401, 24'h150420, 24'h0E0501, 24'h0F0502, 24'h0B0601,
    24'h0C0602, 24'h0D0603, 24'h090701, 24'h0A0702, 24'h080801, 24'h050901, 24'h060902,
    24'h070903, 24'h030A01, 24'h040A02, 24'h020C01, 24'h010D01, 24'h000E01};
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  fault_cond_s cond = '0;
  logic partial_instr = 1'b0;
  logic idle = 1'b0;
  logic slow = 1'b0;
  logic override_return = 1'b0;
  logic [31:0] table_base = 32'h00004000;
  logic tbl_req, tbl_ack, store_req, store_ack, store_to_ctl_block, call_valid;
  logic handler_started, syserr_valid, stopped;
  logic [31:0] tbl_addr, store_data, call_target, call_selector;
  logic [7:0] store_ofs, syserr_vector;
  table_entry_s tbl_entry;
  call_e call_kind;
  nest_e nest;
  int fail_count = 0;
  int total_checks = 0;
  int calls = 0;
  int syserrs = 0;
  int starts = 0;
  logic [31:0] words[$];
  logic [31:0] last_tbl = '0;
  logic saw_override = 1'b0;
  logic ofs_ok = 1'b1;
  logic ctl_seen = 1'b0;

  always #50 ref_clk = ~ref_clk;

  fault_dispatch_unit #(.ADDR_W(32)) fault_dispatch_unit_i (.ref_clk(ref_clk), .resetn(resetn),
    .cond(cond), .partial_instr(partial_instr), .idle(idle), .table_base(table_base),
    .tbl_req(tbl_req), .tbl_addr(tbl_addr), .tbl_ack(tbl_ack), .tbl_entry(tbl_entry),
    .store_req(store_req), .store_ofs(store_ofs), .store_data(store_data),
    .store_to_ctl_block(store_to_ctl_block), .store_ack(store_ack), .call_valid(call_valid),
    .call_kind(call_kind), .call_target(call_target), .call_selector(call_selector),
    .handler_started(handler_started), .override_return(override_return),
    .syserr_valid(syserr_valid), .syserr_vector(syserr_vector), .stopped(stopped), .nest(nest));

  fault_dispatch_partner fault_dispatch_partner_i (.ref_clk(ref_clk), .resetn(resetn),
    .slow(slow), .table_base(table_base), .tbl_req(tbl_req), .tbl_addr(tbl_addr),
    .tbl_ack(tbl_ack), .tbl_entry(tbl_entry), .store_req(store_req), .store_ack(store_ack),
    .call_valid(call_valid), .handler_started(handler_started));

  // Watch the memory side and the pulses; the one-cycle pulses are only visible here.
  always @(posedge ref_clk) begin
    if (store_req === 1'b1 && store_ack === 1'b1) begin
      words.push_back(store_data);
      if (store_ofs !== `REC_WORD_OFS) ofs_ok <= 1'b0;
      if (store_to_ctl_block === 1'b1) ctl_seen <= 1'b1;
    end
    if (tbl_req === 1'b1 && tbl_ack === 1'b1) last_tbl <= tbl_addr;
    if (call_valid === 1'b1) calls <= calls + 1;
    if (syserr_valid === 1'b1) syserrs <= syserrs + 1;
    if (handler_started === 1'b1) starts <= starts + 1;
    if (nest === NEST_OVERRIDE) saw_override <= 1'b1;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic reached(input int which);
    case (which)
      0: return calls > 0;
      1: return syserrs > 0;
      2: return words.size() > 0;
      3: return store_req === 1'b1;
      4: return stopped === 1'b1;
      5: return nest === NEST_NONE;
      6: return nest === NEST_OVERRIDE;
      8: return starts > 0;
      default: return ctl_seen === 1'b1;
    endcase
  endfunction

  // Bounded wait; running out ends the run as a failure.
  task automatic wait_until(input int which);
    int n;
    for (n = 0; n < 300; n++) begin
      @(negedge ref_clk);
      if (reached(which)) return;
    end
    fail_count++;
    $display("BAD at %0t: wait %0d ran out", $time, which);
    end_sim();
  endtask

  task automatic clear();
    words.delete();
    calls = 0;
    syserrs = 0;
    starts = 0;
    saw_override = 1'b0;
    ctl_seen = 1'b0;
    ofs_ok = 1'b1;
  endtask

  // Conditions are levels; one cycle is enough to be taken.
  task automatic raise(input logic [32:0] c);
    @(negedge ref_clk);
    cond = c;
    @(negedge ref_clk);
    cond = '0;
  endtask

  task automatic reset_dut();
    resetn = 1'b0;
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
  endtask

  // One fault through the normal path, judged on its record, fetch and call.
  task automatic do_fault(input logic [32:0] c, input logic [7:0] t, input logic [7:0] s);
    clear();
    raise(c);
    wait_until(0);
    chk(words[0], {8'h00, t, 8'h00, s});
    chk(32'(words.size()), 32'h4);
    chk(words[3], {31'h0, partial_instr});
    chk(ofs_ok, 1'b1);
    chk(last_tbl, table_base + {21'h0, t, 3'h0});
    if (t == `FT_TRACE) chk({30'h0, call_kind}, {30'h0, CALL_TRACE});
    else if (t == `FT_OPER) chk({30'h0, call_kind}, {30'h0, CALL_PROC_LOCAL});
    else if (t == `FT_CONSTR) chk({30'h0, call_kind}, {30'h0, CALL_SUPER});
    else chk(call_target, 32'h00010000 + {16'h0, t, 8'h00});
    if (t == `FT_OPER || t == `FT_CONSTR) chk(call_selector, 32'h00000A00 + {24'h0, t});
    // A new fault before the handler starts would be an override, so wait for it.
    wait_until(8);
    wait_until(5);
  endtask

  // The 24 listed codes, both latencies, both resumption cases, then grouped subtypes.
  task automatic test_codes();
    int i;
    for (i = 0; i < 24; i++) begin
      partial_instr = i[0];
      slow = i[1];
      do_fault(33'h1 << CODES[i][23:16], CODES[i][15:8], CODES[i][7:0]);
    end
    do_fault(33'h024000000, `FT_TRACE, 8'h12);
    do_fault(33'h000090000, `FT_FLOAT, 8'h09);
    $display("codes test done");
  endtask

  // A zero-divide whose record storing suffers a virtual-memory fault.
  task automatic test_override();
    slow = 1'b1;
    partial_instr = 1'b0;
    clear();
    raise(33'h1 << 23);
    wait_until(3);
    raise(33'h1 << 11);
    wait_until(0);
    chk(saw_override, 1'b1);
    chk(last_tbl, table_base);
    chk(words[words.size() - 4], 32'h00030002);
    chk(words[words.size() - 3], 32'h00060001);
    wait_until(5);
    clear();
    override_return = 1'b1;
    @(negedge ref_clk);
    override_return = 1'b0;
    wait_until(0);
    chk(words[0], 32'h00030002);
    chk(last_tbl, table_base + 32'h18);
    wait_until(8);
    wait_until(5);
    $display("override test done");
  endtask

  // Second override escalates, a fault then halts; an idle fault goes to system error.
  task automatic test_syserr();
    clear();
    raise(33'h1 << 23);
    wait_until(3);
    raise(33'h1 << 11);
    wait_until(6);
    wait_until(3);
    raise(33'h1 << 9);
    wait_until(7);
    chk({30'h0, nest}, {30'h0, NEST_SYSERR});
    chk(32'(calls), 32'h0);
    wait_until(3);
    raise(33'h1);
    wait_until(4);
    raise(33'h1 << 8);
    chk(stopped, 1'b1);
    chk(32'(calls), 32'h0);
    reset_dut();
    idle = 1'b1;
    slow = 1'b0;
    clear();
    raise(33'h1 << 8);
    wait_until(1);
    chk(syserr_vector, `SYSERR_VECTOR);
    chk(32'(calls), 32'h0);
    idle = 1'b0;
    $display("system error test done");
  endtask

  initial begin
    reset_dut();
    test_codes();
    test_override();
    test_syserr();
    end_sim();
  end
endmodule
`default_nettype wire
